// file: design/pbmc_defs.svh
// constants of the basic mode control register bank
// assumes a 100 MHz management clock and a 32-bit AXI4-Lite slave port
`ifndef PBMC_DEFS_SVH
`define PBMC_DEFS_SVH

// ============================================================
// register offsets (byte addresses)
`define PBMC_CTRL_OFS 4'h0
`define PBMC_STAT_OFS 4'h4

// ============================================================
// control field positions
`define PBMC_B_SRST 15
`define PBMC_B_LOOP 14
`define PBMC_B_SPEED 13
`define PBMC_B_AN_EN 12
`define PBMC_B_PDOWN 11
`define PBMC_B_ISO 10
`define PBMC_B_RESTART 9
`define PBMC_B_DUPLEX 8
`define PBMC_B_COLTEST 7

// ============================================================
// reset values and bus answers
`define PBMC_CTRL_RST 16'h3100
`define PBMC_RESP_OKAY 2'h0
`define PBMC_RESP_SLVERR 2'h2

// ============================================================
// timing
`define PBMC_CLK_KHZ 100000
`define PBMC_DEAD_MS 720
`define PBMC_SRST_CYCLES 8'h10

`endif

// file: design/pbmc_pkg.sv
// types shared by the basic mode control register bank
// assumes pbmc_defs.svh for all numeric constants
package pbmc_pkg;

    // control sequencer: normal running or soft reset in progress
    typedef enum logic {
        PBMC_RUN,
        PBMC_SRST
    } pbmc_ctl_state_t;

    typedef logic [15:0] pbmc_word16_t;

endpackage

// file: design/pbmc_sync.sv
// two-stage synchroniser for the phy-side status inputs
// assumes inputs may change at any time relative to mclk
`timescale 1ns/1ps
`default_nettype none

module pbmc_sync (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // asynchronous in, synchronised out
    input wire logic [3:0] async_in,
    output logic [3:0] sync_out
);

    logic [3:0] meta_reg;
    logic [3:0] meta_next;
    logic [3:0] sync_reg;
    logic [3:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
        end else if (ce) begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule

`default_nettype wire

// file: design/pbmc_top.sv
// basic mode control register of a 10/100 phy, reached over AXI4-Lite
// assumes one 100 MHz clock; phy status inputs are asynchronous pins
//
// Function
// - soft reset restores defaults, reads one meanwhile
// - loopback bit enables loopback, default zero
// - loopback at 100M starts 720 ms dead time
// - speed bit selects 100M or 10M
// - speed reads negotiated value while negotiating
// - negotiation enable, default one, drives speed/duplex
// - power down keeps management access alive
// - restart bit holds one until negotiation starts
// - restart ignored while negotiation disabled
// - writing zero never disturbs running negotiation
// - manual duplex only applies without negotiation
// - duplex reads negotiated value while negotiating
// - collision test asserts collision while transmitting
// - reserved low bits read zero, ignore writes
// - self-clearing bits clear; read-only ignores writes
`timescale 1ns/1ps
`default_nettype none
`include "pbmc_defs.svh"

module pbmc_top
    import pbmc_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = `PBMC_DEAD_MS * `PBMC_CLK_KHZ
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // phy status pins
    input wire logic tx_active,
    input wire logic an_started,
    input wire logic neg_speed_100,
    input wire logic neg_full_duplex,
    // phy controls
    output logic loopback_en,
    output logic speed_100,
    output logic full_duplex,
    output logic an_enable,
    output logic an_restart,
    output logic power_down,
    output logic isolate,
    output logic collision,
    output logic rx_dead,
    output logic soft_reset_busy
);

    localparam logic [26:0] DEAD_LOAD = 27'(DEAD_CYCLES);

    // ============================================================
    // address decode
    function automatic logic is_ctrl(input logic [3:0] a);
        is_ctrl = (a == `PBMC_CTRL_OFS);
    endfunction

    function automatic logic is_stat(input logic [3:0] a);
        is_stat = (a == `PBMC_STAT_OFS);
    endfunction

    // ============================================================
    // pin synchronisers
    logic [3:0] pins_s;
    logic tx_s;
    logic started_s;
    logic nspd_s;
    logic ndup_s;

    pbmc_sync u_sync (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .async_in({neg_full_duplex, neg_speed_100, an_started, tx_active}),
        .sync_out(pins_s)
    );

    assign tx_s = pins_s[0];
    assign started_s = pins_s[1];
    assign nspd_s = pins_s[2];
    assign ndup_s = pins_s[3];

    // ============================================================
    // state
    pbmc_ctl_state_t state_reg, state_next;
    logic [7:0] srst_cnt_reg, srst_cnt_next;
    logic loop_reg, loop_next;
    logic speed_reg, speed_next;
    logic an_en_reg, an_en_next;
    logic pdown_reg, pdown_next;
    logic iso_reg, iso_next;
    logic restart_reg, restart_next;
    logic duplex_reg, duplex_next;
    logic col_reg, col_next;
    logic [26:0] dead_cnt_reg, dead_cnt_next;
    logic spd_out_reg, spd_out_next;
    logic dup_out_reg, dup_out_next;
    logic col_out_reg, col_out_next;
    logic dead_out_reg, dead_out_next;
    logic aw_have_reg, aw_have_next;
    logic [3:0] aw_addr_reg, aw_addr_next;
    logic w_have_reg, w_have_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    logic busy;
    logic do_write;
    logic srst_start;
    logic dead_start;
    pbmc_word16_t ctrl_rd_val;
    logic [31:0] stat_rd_val;

    assign busy = (state_reg == PBMC_SRST);
    assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    assign srst_start = do_write && !busy && is_ctrl(aw_addr_reg) && w_strb_reg[1]
        && w_data_reg[`PBMC_B_SRST];

    assign ctrl_rd_val = {busy, loop_reg, an_en_reg ? nspd_s : speed_reg, an_en_reg,
        pdown_reg, iso_reg, restart_reg, an_en_reg ? ndup_s : duplex_reg, col_reg, 7'h00};
    assign stat_rd_val = {27'h0000000, ndup_s, nspd_s, dead_cnt_reg != 27'h0000000,
        restart_reg, busy};

    // ============================================================
    // next-state logic
    always_comb begin
        state_next = state_reg;
        srst_cnt_next = srst_cnt_reg;
        loop_next = loop_reg;
        speed_next = speed_reg;
        an_en_next = an_en_reg;
        pdown_next = pdown_reg;
        iso_next = iso_reg;
        restart_next = restart_reg;
        duplex_next = duplex_reg;
        col_next = col_reg;
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        dead_start = 1'b0;

        if (restart_reg && started_s) begin
            restart_next = 1'b0;
        end

        // bus stays live whatever power down says
        if (s_axi_awvalid && awready_reg) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end

        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `PBMC_RESP_OKAY;
            if (is_ctrl(aw_addr_reg)) begin
                // writes during soft reset are dropped
                if (!busy && w_strb_reg[1] && !w_data_reg[`PBMC_B_SRST]) begin
                    loop_next = w_data_reg[`PBMC_B_LOOP];
                    speed_next = w_data_reg[`PBMC_B_SPEED];
                    an_en_next = w_data_reg[`PBMC_B_AN_EN];
                    pdown_next = w_data_reg[`PBMC_B_PDOWN];
                    iso_next = w_data_reg[`PBMC_B_ISO];
                    duplex_next = w_data_reg[`PBMC_B_DUPLEX];
                    // zero leaves a pending restart alone
                    if (w_data_reg[`PBMC_B_RESTART]) begin
                        restart_next = 1'b1;
                    end
                end
                if (!busy && !srst_start && w_strb_reg[0]) begin
                    col_next = w_data_reg[`PBMC_B_COLTEST];
                end
            end else if (!is_stat(aw_addr_reg)) begin
                bresp_next = `PBMC_RESP_SLVERR;
            end
        end

        // restart has no effect without negotiation
        if (!an_en_next) begin
            restart_next = 1'b0;
        end

        // dead time after loopback at 100M
        if (loop_next && !loop_reg && spd_out_reg) begin
            dead_start = 1'b1;
        end

        case (state_reg)
            PBMC_RUN: begin
                if (srst_start) begin
                    state_next = PBMC_SRST;
                    srst_cnt_next = `PBMC_SRST_CYCLES - 8'h01;
                end
            end
            PBMC_SRST: begin
                if (srst_cnt_reg == 8'h00) begin
                    state_next = PBMC_RUN;
                end else begin
                    srst_cnt_next = srst_cnt_reg - 8'h01;
                end
            end
            default: begin
                state_next = PBMC_RUN;
            end
        endcase
        if (state_next == PBMC_SRST) begin
            {loop_next, speed_next, an_en_next, pdown_next, iso_next, restart_next,
                duplex_next, col_next} = 8'(`PBMC_CTRL_RST >> 7);
            dead_start = 1'b0;
        end

        if (dead_start) begin
            dead_cnt_next = DEAD_LOAD;
        end else if (state_next == PBMC_SRST) begin
            dead_cnt_next = 27'h0000000;
        end else if (dead_cnt_reg != 27'h0000000) begin
            dead_cnt_next = dead_cnt_reg - 27'h0000001;
        end else begin
            dead_cnt_next = dead_cnt_reg;
        end

        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = `PBMC_RESP_OKAY;
            if (is_ctrl(s_axi_araddr)) begin
                rdata_next = {16'h0000, ctrl_rd_val};
            end else if (is_stat(s_axi_araddr)) begin
                rdata_next = stat_rd_val;
            end else begin
                rdata_next = 32'h00000000;
                rresp_next = `PBMC_RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end

        awready_next = !aw_have_next;
        wready_next = !w_have_next;
        arready_next = !rvalid_next;

        // manual duplex only when not negotiating
        spd_out_next = an_en_next ? nspd_s : speed_next;
        dup_out_next = an_en_next ? ndup_s : duplex_next;
        col_out_next = col_next && tx_s;
        dead_out_next = dead_cnt_next != 27'h0000000;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= PBMC_RUN;
            srst_cnt_reg <= 8'h00;
            {loop_reg, speed_reg, an_en_reg, pdown_reg, iso_reg, restart_reg,
                duplex_reg, col_reg} <= 8'(`PBMC_CTRL_RST >> 7);
            dead_cnt_reg <= 27'h0000000;
            spd_out_reg <= 1'b0;
            dup_out_reg <= 1'b0;
            col_out_reg <= 1'b0;
            dead_out_reg <= 1'b0;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= 2'h0;
        end else if (ce) begin
            state_reg <= state_next;
            srst_cnt_reg <= srst_cnt_next;
            loop_reg <= loop_next;
            speed_reg <= speed_next;
            an_en_reg <= an_en_next;
            pdown_reg <= pdown_next;
            iso_reg <= iso_next;
            restart_reg <= restart_next;
            duplex_reg <= duplex_next;
            col_reg <= col_next;
            dead_cnt_reg <= dead_cnt_next;
            spd_out_reg <= spd_out_next;
            dup_out_reg <= dup_out_next;
            col_out_reg <= col_out_next;
            dead_out_reg <= dead_out_next;
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ============================================================
    // outputs
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign loopback_en = loop_reg;
    assign speed_100 = spd_out_reg;
    assign full_duplex = dup_out_reg;
    assign an_enable = an_en_reg;
    assign an_restart = restart_reg;
    assign power_down = pdown_reg;
    assign isolate = iso_reg;
    assign collision = col_out_reg;
    assign rx_dead = dead_out_reg;
    assign soft_reset_busy = state_reg == PBMC_SRST;

    // ============================================================
    // checks
    logic [8:0] busy_len_reg;

    always_ff @(posedge mclk) begin
        if (reset || !busy) begin
            busy_len_reg <= 9'h000;
        end else if (ce) begin
            busy_len_reg <= busy_len_reg + 9'h001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence srst_req_s;
        ce && srst_start;
    endsequence

    sequence srst_end_s;
        ce && busy && srst_cnt_reg == 8'h00;
    endsequence

    srst_reads_one_a: assert property (srst_req_s |=> busy && ctrl_rd_val[15])
        else $error("soft reset bit not reading one");
    srst_defaults_a: assert property (srst_end_s |=> !busy && !ctrl_rd_val[15]
        && {loop_reg, speed_reg, an_en_reg, pdown_reg, iso_reg, restart_reg, duplex_reg,
        col_reg} == 8'(`PBMC_CTRL_RST >> 7)) else $error("defaults missing after soft reset");
    srst_bounded_a: assert property (busy_len_reg <= 9'h010)
        else $error("soft reset too long");
    loop_out_a: assert property (ce && loop_next != loop_reg |=> loopback_en == $past(loop_next))
        else $error("loopback output wrong");
    dead_load_a: assert property (ce && dead_start |=> rx_dead && dead_cnt_reg == DEAD_LOAD)
        else $error("dead time not started");
    speed_read_a: assert property (an_en_reg |-> ctrl_rd_val[13] == nspd_s)
        else $error("speed readback not negotiated");
    duplex_read_a: assert property (an_en_reg |-> ctrl_rd_val[8] == ndup_s)
        else $error("duplex readback not negotiated");
    restart_off_a: assert property (!an_en_reg |-> !an_restart)
        else $error("restart pending without negotiation");
    restart_hold_a: assert property (ce && restart_reg && !started_s && an_en_next
        && !srst_start |=> restart_reg) else $error("restart dropped early");
    rsvd_zero_a: assert property (ctrl_rd_val[6:0] == 7'h00)
        else $error("reserved bits not zero");
    col_test_a: assert property (ce && col_reg && tx_s && !busy && !do_write |=> collision)
        else $error("collision not asserted under test");

endmodule

`default_nettype wire

// file: dv/pbmc_phy_model.sv
// phy-side partner model: answers restart requests, offers negotiated results
// assumes the bench sets negotiated values, transmit activity and answer delay
`timescale 1ns/1ps
`default_nettype none

module pbmc_phy_model (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // bench settings
    input wire logic [7:0] delay,
    input wire logic spd_cfg,
    input wire logic dup_cfg,
    input wire logic tx_cfg,
    // restart request from the block, phy status toward the block
    input wire logic an_restart,
    output logic an_started,
    output logic neg_speed_100,
    output logic neg_full_duplex,
    output logic tx_active
);
    logic [7:0] wait_cnt;

    assign neg_speed_100 = spd_cfg;
    assign neg_full_duplex = dup_cfg;
    assign tx_active = tx_cfg;

    always @(posedge mclk) begin
        if (reset || !an_restart) begin
            wait_cnt <= 8'h00;
            an_started <= 1'b0;
        end else if (wait_cnt >= delay) begin
            an_started <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule

`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the basic mode control register bank
// assumes pbmc_top with a short dead time and the phy partner model
`timescale 1ns/1ps
`default_nettype none
`include "pbmc_defs.svh"

module tb_top;
    localparam int DEAD = 20;
    localparam logic [3:0] CTRL = `PBMC_CTRL_OFS;
    localparam logic [1:0] OK = `PBMC_RESP_OKAY;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    typedef struct {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } pbmc_exp_t;

    logic mclk, reset, ce;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic tx_active, an_started, neg_speed_100, neg_full_duplex;
    logic loopback_en, speed_100, full_duplex, an_enable, an_restart;
    logic power_down, isolate, collision, rx_dead, soft_reset_busy;
    logic [7:0] delay;
    logic spd_cfg, dup_cfg, tx_cfg;
    int checks = 0;
    int miscompares = 0;
    int n;
    pbmc_exp_t rq[$];
    logic [1:0] wq[$];
    pbmc_exp_t mon_e;

    pbmc_top #(.DEAD_CYCLES(DEAD)) i_dut (
        .mclk(mclk), .reset(reset), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .tx_active(tx_active),
        .an_started(an_started), .neg_speed_100(neg_speed_100),
        .neg_full_duplex(neg_full_duplex), .loopback_en(loopback_en),
        .speed_100(speed_100), .full_duplex(full_duplex), .an_enable(an_enable),
        .an_restart(an_restart), .power_down(power_down), .isolate(isolate),
        .collision(collision), .rx_dead(rx_dead), .soft_reset_busy(soft_reset_busy)
    );

    pbmc_phy_model i_phy (
        .mclk(mclk), .reset(reset), .delay(delay), .spd_cfg(spd_cfg),
        .dup_cfg(dup_cfg), .tx_cfg(tx_cfg), .an_restart(an_restart),
        .an_started(an_started), .neg_speed_100(neg_speed_100),
        .neg_full_duplex(neg_full_duplex), .tx_active(tx_active)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ========
    // compare, verdict, bus master
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // control word while negotiating: speed and duplex show the partner's result
    function automatic logic [31:0] an_word(input logic [31:0] b);
        return b | {18'h0, spd_cfg, 4'h0, dup_cfg, 8'h0};
    endfunction

    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        bit aw;
        bit w;
        wq.push_back(r);
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge mclk);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge mclk);
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic [1:0] r);
        rq.push_back('{d, m, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge mclk);
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask

    // ========
    // response monitor: oldest note against each answer
    always @(posedge mclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            mon_e = rq.pop_front();
            chk(s_axi_rdata & mon_e.m, mon_e.d);
            chk(32'(s_axi_rresp), 32'(mon_e.r));
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            chk(32'(s_axi_bresp), 32'(wq.pop_front()));
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        $display("ERROR %0t: run did not finish", $time);
        print_verdict();
    end

    // ========
    // tests
    initial begin
        ce = 1'b1;
        reset = 1'b1;
        s_axi_awaddr = 4'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_araddr = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        delay = 8'h01;
        tx_cfg = 1'b0;
        void'($urandom(39490));
        spd_cfg = 1'($urandom);
        dup_cfg = 1'($urandom);
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (6) @(posedge mclk);
        axr(CTRL, an_word(32'h1000), ALL, OK);
        chk(32'(an_enable), 32'h1);
        chk(32'(speed_100), 32'(spd_cfg));
        $display("test defaults done");
        axw(CTRL, 32'h0000_4bff, OK);
        repeat (3) @(posedge mclk);
        chk(32'(rx_dead), 32'(spd_cfg));
        chk(32'(loopback_en), 32'h1);
        chk(32'(power_down), 32'h1);
        chk(32'(speed_100), 32'h0);
        chk(32'(full_duplex), 32'h1);
        chk(32'(an_restart), 32'h0);
        chk(32'(isolate), 32'h0);
        axr(CTRL, 32'h0000_4980, ALL, OK);
        tx_cfg <= 1'b1;
        repeat (5) @(posedge mclk);
        chk(32'(collision), 32'h1);
        tx_cfg <= 1'b0;
        repeat (DEAD + 5) @(posedge mclk);
        chk(32'(collision), 32'h0);
        chk(32'(rx_dead), 32'h0);
        $display("test manual mode done");
        spd_cfg <= 1'($urandom);
        dup_cfg <= 1'($urandom);
        delay <= 8'd40;
        axw(CTRL, 32'h0000_1200, OK);
        axw(CTRL, 32'h0000_1000, OK);
        chk(32'(an_restart), 32'h1);
        axr(CTRL, an_word(32'h1200), ALL, OK);
        n = 0;
        while (an_restart !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        chk(32'(n < 100), 32'h1);
        axr(CTRL, an_word(32'h1000), ALL, OK);
        chk(32'(speed_100), 32'(spd_cfg));
        chk(32'(full_duplex), 32'(dup_cfg));
        $display("test negotiation done");
        axr(4'h8, 32'h0, ALL, `PBMC_RESP_SLVERR);
        axw(4'hc, 32'h0000_ffff, `PBMC_RESP_SLVERR);
        axw(`PBMC_STAT_OFS, 32'h0000_ffff, OK);
        axr(CTRL, an_word(32'h1000), ALL, OK);
        $display("test bad access done");
        axw(CTRL, 32'h0000_5800, OK);
        axw(CTRL, 32'h0000_8000, OK);
        axr(CTRL, 32'h0000_8000, 32'h0000_8000, OK);
        axr(`PBMC_STAT_OFS, 32'h0000_0001, 32'h0000_0001, OK);
        axw(CTRL, 32'h0000_4000, OK);
        n = 0;
        while (soft_reset_busy !== 1'b0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        chk(32'(n < 20), 32'h1);
        repeat (2) @(posedge mclk);
        axr(CTRL, an_word(32'h1000), ALL, OK);
        chk(32'(loopback_en), 32'h0);
        chk(32'(power_down), 32'h0);
        chk(32'(rx_dead), 32'h0);
        $display("test soft reset done");
        print_verdict();
    end
endmodule

`default_nettype wire
